// ===== src/dlc_clk_gen.v
// Output pixel clock generator: divide channel A clock or multiply reference
`timescale 1ns/1ns
`include "dlc_defines.vh"

module dlc_clk_gen #(
  parameter CNT_W = 12,
  parameter LOSS_CYC = `DLC_LOSS_NS * `DLC_CLK_MHZ / 1000
) (
  input wire clk_i,
  input wire nrst_i,
  input wire src_cha_i,
  input wire cha_clk_i,
  input wire ref_clk_i,
  input wire [4:0] div_i,
  input wire [1:0] mul_i,
  output reg pix_tick_o,
  output reg pix_clk_o,
  output reg src_alive_o
);

  reg cha_s1_reg;
  reg cha_s2_reg;
  reg cha_s3_reg;
  reg ref_s1_reg;
  reg ref_s2_reg;
  reg ref_s3_reg;
  reg [4:0] div_cnt_reg;
  reg [CNT_W-1:0] per_cnt_reg;
  reg [CNT_W-1:0] period_reg;
  reg [CNT_W-1:0] acc_reg;
  reg [CNT_W-1:0] loss_cnt_reg;
  reg [CNT_W-1:0] acc_sum;
  reg tick_next;

  wire cha_rise = cha_s2_reg & ~cha_s3_reg;
  wire ref_rise = ref_s2_reg & ~ref_s3_reg;
  wire src_rise = src_cha_i ? cha_rise : ref_rise;
  // A zero divider is taken as one so the output never stops
  wire [4:0] div_eff = (div_i == 5'h00) ? 5'h01 : div_i;
  wire [CNT_W-1:0] mul_eff = {{(CNT_W-2){1'b0}}, mul_i} + {{(CNT_W-1){1'b0}}, 1'b1};

  always @* begin
    acc_sum = acc_reg + mul_eff;
    tick_next = 1'b0;
    if (src_cha_i) begin
      tick_next = cha_rise && (div_cnt_reg == div_eff - 5'h01);
    end else begin
      tick_next = (period_reg != {CNT_W{1'b0}}) && (acc_sum >= period_reg);
    end
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      cha_s1_reg <= 1'b0;
      cha_s2_reg <= 1'b0;
      cha_s3_reg <= 1'b0;
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
      div_cnt_reg <= 5'h00;
      per_cnt_reg <= {CNT_W{1'b0}};
      period_reg <= {CNT_W{1'b0}};
      acc_reg <= {CNT_W{1'b0}};
      loss_cnt_reg <= {CNT_W{1'b0}};
      pix_tick_o <= 1'b0;
      pix_clk_o <= 1'b0;
      src_alive_o <= 1'b0;
    end else begin
      cha_s1_reg <= cha_clk_i;
      cha_s2_reg <= cha_s1_reg;
      cha_s3_reg <= cha_s2_reg;
      ref_s1_reg <= ref_clk_i;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
      if (cha_rise) begin
        div_cnt_reg <= tick_next || (div_cnt_reg >= div_eff) ? 5'h00 : div_cnt_reg + 5'h01;
      end
      // Reference period in system cycles feeds a fractional accumulator
      if (ref_rise) begin
        period_reg <= per_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        per_cnt_reg <= {CNT_W{1'b0}};
      end else if (per_cnt_reg != {CNT_W{1'b1}}) begin
        per_cnt_reg <= per_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (!src_cha_i) begin
        acc_reg <= tick_next ? acc_sum - period_reg : acc_sum;
      end else begin
        acc_reg <= {CNT_W{1'b0}};
      end
      pix_tick_o <= tick_next;
      if (tick_next) begin
        pix_clk_o <= ~pix_clk_o;
      end
      if (src_rise) begin
        loss_cnt_reg <= {CNT_W{1'b0}};
        src_alive_o <= 1'b1;
      end else if (loss_cnt_reg == LOSS_CYC[CNT_W-1:0]) begin
        src_alive_o <= 1'b0;
      end else begin
        loss_cnt_reg <= loss_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // dlc_clk_gen

// ===== src/dlc_defines.vh
// Constants for the display bridge mode routing and pixel clock configuration block
`ifndef DLC_DEFINES_VH
`define DLC_DEFINES_VH

// Register offsets
`define DLC_ADDR_OUT_CLK 8'h0a
`define DLC_ADDR_DIV_MUL 8'h0b
`define DLC_ADDR_IN_MODE 8'h10
`define DLC_ADDR_IN_RANGE 8'h12
`define DLC_ADDR_LINK_CFG 8'h18
`define DLC_ADDR_DEPTH 8'h40
`define DLC_ADDR_STATUS 8'h41
`define DLC_ADDR_CNT_LO 8'h42
`define DLC_ADDR_CNT_HI 8'h43
`define DLC_REG_RST 8'h00

// Field positions
`define DLC_SRC_BIT 0
`define DLC_ORANGE_HI 3
`define DLC_ORANGE_LO 1
`define DLC_DIV_HI 7
`define DLC_DIV_LO 3
`define DLC_MUL_HI 1
`define DLC_MUL_LO 0
`define DLC_LR_BIT 7
`define DLC_CHM_HI 6
`define DLC_CHM_LO 5
`define DLC_LINK_BIT 4
`define DLC_DEPTH_BIT 0
`define DLC_DEPTH18_MASK 8'hfc

// Input channel mode encodings
`define DLC_CHM_DUAL 2'h0
`define DLC_CHM_SINGLE 2'h1
`define DLC_CHM_TWO 2'h2

// Clock range codes
`define DLC_OUT_CLK_CHA_LOW 8'h03
`define DLC_IN_RANGE_150 8'h1e

// Timing
`define DLC_CLK_MHZ 50
`define DLC_LOSS_NS 10000

`endif

// ===== src/dlc_mode_clock_cfg.v
// Mode routing of two pixel inputs onto two output links, with pixel clock setup
`timescale 1ns/1ns
`include "dlc_defines.vh"

module dlc_mode_clock_cfg #(
  parameter PIX_W = 24
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire cha_clk_i,
  input wire ref_clk_i,
  input wire [PIX_W-1:0] in_a_data_i,
  input wire in_a_valid_i,
  input wire in_a_last_i,
  output reg in_a_ready_o,
  input wire [PIX_W-1:0] in_b_data_i,
  input wire in_b_valid_i,
  input wire in_b_last_i,
  output reg in_b_ready_o,
  output reg [PIX_W-1:0] out_a_data_o,
  output reg out_a_valid_o,
  output reg [PIX_W-1:0] out_b_data_o,
  output reg out_b_valid_o,
  output reg out_b_enable_o,
  output wire pix_clk_o,
  output wire pix_tick_o,
  output wire [2:0] out_clk_band_o,
  output wire [7:0] in_a_clk_band_o,
  output reg band_preset_o,
  output reg [2:0] mode_o
);

  // Decoded routings; code 7 lets nothing through
  localparam MODE_SIN_SL = 3'h0;
  localparam MODE_SIN_DL = 3'h1;
  localparam MODE_OE_SL = 3'h2;
  localparam MODE_OE_DL = 3'h3;
  localparam MODE_LR_SL = 3'h4;
  localparam MODE_LR_DL = 3'h5;
  localparam MODE_TWO = 3'h6;
  localparam MODE_NONE = 3'h7;

  reg [7:0] out_clk_reg;
  reg [7:0] div_mul_reg;
  reg [7:0] in_mode_reg;
  reg [7:0] in_range_reg;
  reg [7:0] link_cfg_reg;
  reg [7:0] depth_reg;
  reg [15:0] pix_cnt_reg;
  reg [2:0] mode_reg;
  reg phase_reg;
  reg side_reg;
  reg pair_reg;
  reg [PIX_W-1:0] hold_reg;

  reg [2:0] mode_next;
  reg sel_b;
  reg take_a;
  reg take_b;
  reg [PIX_W-1:0] cur_pix;
  reg cur_last;
  reg pair_mode;
  reg [7:0] rd_val;

  wire src_alive;
  wire [PIX_W-1:0] pix_a;
  wire [PIX_W-1:0] pix_b;
  wire [15:0] take_inc;

  // Mode from link bit, left/right bit and channel-mode field
  function [2:0] dlc_decode;
    input link_single;
    input half_split;
    input [1:0] chm;
    begin
      case (chm)
        `DLC_CHM_SINGLE: begin
          dlc_decode = link_single ? MODE_SIN_SL : MODE_SIN_DL;
        end
        `DLC_CHM_DUAL: begin
          if (half_split) begin
            dlc_decode = link_single ? MODE_LR_SL : MODE_LR_DL;
          end else begin
            dlc_decode = link_single ? MODE_OE_SL : MODE_OE_DL;
          end
        end
        `DLC_CHM_TWO: begin
          dlc_decode = link_single ? MODE_NONE : MODE_TWO;
        end
        default: begin
          dlc_decode = MODE_NONE;
        end
      endcase
    end
  endfunction

  // In 18 bpp the two low bits of every colour are cleared
  function [PIX_W-1:0] dlc_depth;
    input [PIX_W-1:0] pix;
    input full_depth;
    begin
      dlc_depth = full_depth ? pix : (pix & {PIX_W/8{`DLC_DEPTH18_MASK}});
    end
  endfunction

  assign pix_a = dlc_depth(in_a_data_i, depth_reg[`DLC_DEPTH_BIT]);
  assign pix_b = dlc_depth(in_b_data_i, depth_reg[`DLC_DEPTH_BIT]);
  // Two-input modes may take on both channels in one cycle; both count
  assign take_inc = {15'h0000, take_a} + {15'h0000, take_b};
  // PLL range settings are driven straight from what software wrote
  assign out_clk_band_o = out_clk_reg[`DLC_ORANGE_HI:`DLC_ORANGE_LO];
  assign in_a_clk_band_o = in_range_reg;

  dlc_clk_gen u_clk_gen (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .src_cha_i(out_clk_reg[`DLC_SRC_BIT]),
    .cha_clk_i(cha_clk_i),
    .ref_clk_i(ref_clk_i),
    .div_i(div_mul_reg[`DLC_DIV_HI:`DLC_DIV_LO]),
    .mul_i(div_mul_reg[`DLC_MUL_HI:`DLC_MUL_LO]),
    .pix_tick_o(pix_tick_o),
    .pix_clk_o(pix_clk_o),
    .src_alive_o(src_alive)
  );

  // Pixel acceptance; each output pixel slot costs one pixel clock tick
  always @* begin
    mode_next = dlc_decode(link_cfg_reg[`DLC_LINK_BIT], in_mode_reg[`DLC_LR_BIT],
      in_mode_reg[`DLC_CHM_HI:`DLC_CHM_LO]);
    sel_b = 1'b0;
    take_a = 1'b0;
    take_b = 1'b0;
    in_a_ready_o = 1'b0;
    in_b_ready_o = 1'b0;
    pair_mode = (mode_reg == MODE_SIN_DL) || (mode_reg == MODE_LR_DL);
    case (mode_reg)
      MODE_SIN_SL, MODE_SIN_DL: begin
        in_a_ready_o = pix_tick_o;
      end
      MODE_OE_SL: begin
        sel_b = phase_reg;
        in_a_ready_o = pix_tick_o & ~sel_b;
        in_b_ready_o = pix_tick_o & sel_b;
      end
      MODE_OE_DL: begin
        // Odd and even pixels leave together, so each waits for the other
        in_a_ready_o = pix_tick_o & in_b_valid_i;
        in_b_ready_o = pix_tick_o & in_a_valid_i;
      end
      MODE_LR_SL, MODE_LR_DL: begin
        sel_b = side_reg;
        in_a_ready_o = pix_tick_o & ~sel_b;
        in_b_ready_o = pix_tick_o & sel_b;
      end
      MODE_TWO: begin
        in_a_ready_o = pix_tick_o;
        in_b_ready_o = pix_tick_o;
      end
      default: begin
        in_a_ready_o = 1'b0;
      end
    endcase
    // No pixel is taken while the routing changes, so none is split across modes
    if (mode_next != mode_reg) begin
      in_a_ready_o = 1'b0;
      in_b_ready_o = 1'b0;
    end
    take_a = in_a_ready_o & in_a_valid_i;
    take_b = in_b_ready_o & in_b_valid_i;
    cur_pix = sel_b ? pix_b : pix_a;
    cur_last = sel_b ? in_b_last_i : in_a_last_i;
  end

  // Register read value
  always @* begin
    case (addr_i)
      `DLC_ADDR_OUT_CLK: begin
        rd_val = out_clk_reg;
      end
      `DLC_ADDR_DIV_MUL: begin
        rd_val = div_mul_reg;
      end
      `DLC_ADDR_IN_MODE: begin
        rd_val = in_mode_reg;
      end
      `DLC_ADDR_IN_RANGE: begin
        rd_val = in_range_reg;
      end
      `DLC_ADDR_LINK_CFG: begin
        rd_val = link_cfg_reg;
      end
      `DLC_ADDR_DEPTH: begin
        rd_val = depth_reg;
      end
      `DLC_ADDR_STATUS: begin
        rd_val = {1'b0, pair_reg, side_reg, phase_reg, src_alive, mode_reg};
      end
      // Halves are read separately; software must allow for a carry between reads
      `DLC_ADDR_CNT_LO: begin
        rd_val = pix_cnt_reg[7:0];
      end
      `DLC_ADDR_CNT_HI: begin
        rd_val = pix_cnt_reg[15:8];
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Register file
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      out_clk_reg <= `DLC_REG_RST;
      div_mul_reg <= `DLC_REG_RST;
      in_mode_reg <= `DLC_REG_RST;
      in_range_reg <= `DLC_REG_RST;
      link_cfg_reg <= `DLC_REG_RST;
      depth_reg <= `DLC_REG_RST;
      rdata_o <= 8'h00;
      band_preset_o <= 1'b0;
    end else begin
      // Zero outside the read slot, so the bus can be or-ed with others
      rdata_o <= rd_i ? rd_val : 8'h00;
      if (wr_i) begin
        case (addr_i)
          `DLC_ADDR_OUT_CLK: begin
            out_clk_reg <= wdata_i;
          end
          `DLC_ADDR_DIV_MUL: begin
            div_mul_reg <= wdata_i;
          end
          `DLC_ADDR_IN_MODE: begin
            in_mode_reg <= wdata_i;
          end
          `DLC_ADDR_IN_RANGE: begin
            in_range_reg <= wdata_i;
          end
          `DLC_ADDR_LINK_CFG: begin
            link_cfg_reg <= wdata_i;
          end
          `DLC_ADDR_DEPTH: begin
            depth_reg <= wdata_i;
          end
          // Unmapped and read-only offsets ignore writes here; a write to the count low byte clears the pixel count
          default: begin
            depth_reg <= depth_reg;
          end
        endcase
      end
      // Flags the documented preset pair: channel A source, low output band, 150 MHz input
      band_preset_o <= (out_clk_reg == `DLC_OUT_CLK_CHA_LOW) &&
        (in_range_reg == `DLC_IN_RANGE_150);
    end
  end

  // Pixel sequencing and output links
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_reg <= MODE_NONE;
      mode_o <= MODE_NONE;
      phase_reg <= 1'b0;
      side_reg <= 1'b0;
      pair_reg <= 1'b0;
      hold_reg <= {PIX_W{1'b0}};
      out_a_data_o <= {PIX_W{1'b0}};
      out_b_data_o <= {PIX_W{1'b0}};
      out_a_valid_o <= 1'b0;
      out_b_valid_o <= 1'b0;
      out_b_enable_o <= 1'b0;
      pix_cnt_reg <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
      mode_o <= mode_reg;
      // Link B is marked in use only in the modes that drive it
      out_b_enable_o <= (mode_reg == MODE_SIN_DL) || (mode_reg == MODE_OE_DL) ||
        (mode_reg == MODE_LR_DL) || (mode_reg == MODE_TWO);
      out_a_valid_o <= 1'b0;
      out_b_valid_o <= 1'b0;
      if (wr_i && (addr_i == `DLC_ADDR_CNT_LO)) begin
        pix_cnt_reg <= 16'h0000;
      end else if (take_a || take_b) begin
        pix_cnt_reg <= pix_cnt_reg + take_inc;
      end
      // A mode change restarts every pairing and side sequence
      if (mode_next != mode_reg) begin
        phase_reg <= 1'b0;
        side_reg <= 1'b0;
        pair_reg <= 1'b0;
      end else if (mode_reg == MODE_OE_DL) begin
        if (take_a) begin
          out_a_data_o <= pix_a;
          out_b_data_o <= pix_b;
          out_a_valid_o <= 1'b1;
          out_b_valid_o <= 1'b1;
        end
      end else if (mode_reg == MODE_TWO) begin
        if (take_a) begin
          out_a_data_o <= pix_a;
          out_a_valid_o <= 1'b1;
        end
        if (take_b) begin
          out_b_data_o <= pix_b;
          out_b_valid_o <= 1'b1;
        end
      end else if (take_a || take_b) begin
        if (mode_reg == MODE_OE_SL) begin
          phase_reg <= ~phase_reg;
        end
        if ((mode_reg == MODE_LR_SL || mode_reg == MODE_LR_DL) && cur_last) begin
          side_reg <= ~side_reg;
        end
        if (!pair_mode) begin
          out_a_data_o <= cur_pix;
          out_a_valid_o <= 1'b1;
        end else if (!pair_reg && cur_last) begin
          // Odd pixel count on a line: last pixel goes out with a blank partner
          out_a_data_o <= cur_pix;
          out_b_data_o <= {PIX_W{1'b0}};
          out_a_valid_o <= 1'b1;
          out_b_valid_o <= 1'b1;
        end else if (!pair_reg) begin
          hold_reg <= cur_pix;
          pair_reg <= 1'b1;
        end else begin
          out_a_data_o <= hold_reg;
          out_b_data_o <= cur_pix;
          out_a_valid_o <= 1'b1;
          out_b_valid_o <= 1'b1;
          pair_reg <= 1'b0;
        end
      end
    end
  end

endmodule // dlc_mode_clock_cfg

// ===== test/dlc_cfg_checker.sv
// Port assertions for the mode routing and pixel clock block
`timescale 1ns/1ns
module dlc_cfg_checker (
  input wire clk_i,
  input wire nrst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire in_a_valid_i,
  input wire in_a_ready_o,
  input wire in_b_valid_i,
  input wire in_b_ready_o,
  input wire out_a_valid_o,
  input wire out_b_valid_o,
  input wire out_b_enable_o,
  input wire pix_tick_o,
  input wire [2:0] out_clk_band_o,
  input wire [7:0] in_a_clk_band_o,
  input wire band_preset_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wr(a);
    wr_i && addr_i == a;
  endsequence
  sequence s_take;
    (in_a_valid_i && in_a_ready_o) || (in_b_valid_i && in_b_ready_o);
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_out_band: assert property (s_wr(8'h0a) |=> out_clk_band_o == $past(wdata_i[3:1]))
    else $error("output band field not taken");
  a_in_band: assert property (s_wr(8'h12) |=> in_a_clk_band_o == $past(wdata_i))
    else $error("input band register not taken");
  a_preset_codes: assert property (band_preset_o |->
    $past(in_a_clk_band_o) == 8'h1e && $past(out_clk_band_o) == 3'h1)
    else $error("preset flag without preset codes");
  a_ready_tick: assert property (in_a_ready_o || in_b_ready_o |-> pix_tick_o)
    else $error("ready outside pixel slot");
  a_out_cause: assert property (out_a_valid_o |->
    $past((in_a_valid_i && in_a_ready_o) || (in_b_valid_i && in_b_ready_o)))
    else $error("output pixel without a take");
  a_valid_pulse: assert property (out_a_valid_o |=> !out_a_valid_o)
    else $error("output valid longer than one cycle");
  a_b_enabled: assert property (out_b_valid_o |-> out_b_enable_o)
    else $error("link B data while link B unused");
  c_take_out: cover property (s_take ##1 out_a_valid_o);
endmodule // dlc_cfg_checker

bind dlc_mode_clock_cfg dlc_cfg_checker u_chk (.clk_i, .nrst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .in_a_valid_i, .in_a_ready_o, .in_b_valid_i, .in_b_ready_o,
  .out_a_valid_o, .out_b_valid_o, .out_b_enable_o, .pix_tick_o, .out_clk_band_o,
  .in_a_clk_band_o, .band_preset_o);

// ===== test/dlc_host_model.sv
// Host video source with channel A clock lane and reference oscillator
`timescale 1ns/1ns
module dlc_host_model (
  input wire clk_i,
  input wire nrst_i,
  input wire en_i,
  input wire a_ready_i,
  input wire b_ready_i,
  output reg cha_clk_o,
  output reg ref_clk_o,
  output reg [23:0] a_data_o,
  output reg a_valid_o,
  output reg a_last_o,
  output reg [23:0] b_data_o,
  output reg b_valid_o,
  output reg b_last_o
);
  reg [7:0] cnt_a = 8'h00;
  reg [7:0] cnt_b = 8'h00;
  reg [5:0] ph = 6'h00;
  // Reference runs free; channel A lane stands still outside streams
  always @(posedge clk_i) begin
    ph <= (ph == 6'd59) ? 6'h00 : ph + 6'h01;
    ref_clk_o <= (ph % 20) < 10;
    cha_clk_o <= en_i && ((ph % 6) < 3);
    a_valid_o <= nrst_i && en_i;
    b_valid_o <= nrst_i && en_i;
    if (!nrst_i || !en_i) begin
      cnt_a <= 8'h00;
      cnt_b <= 8'h00;
    end else begin
      if (a_valid_o && a_ready_i) cnt_a <= cnt_a + 8'h01;
      if (b_valid_o && b_ready_i) cnt_b <= cnt_b + 8'h01;
    end
  end
  // Idle data lines carry the inverted pattern so a stale value is never mistaken for a pixel
  always @* begin
    a_data_o = a_valid_o ? {16'h1327, cnt_a} : ~{16'h1327, cnt_a};
    b_data_o = b_valid_o ? {16'h576b, cnt_b} : ~{16'h576b, cnt_b};
    a_last_o = a_valid_o && (cnt_a[1:0] == 2'h3);
    b_last_o = b_valid_o && (cnt_b[1:0] == 2'h3);
  end
endmodule // dlc_host_model

// ===== test/tb_dlc_mode_clock_cfg.sv
// Self-checking bench for the mode routing and pixel clock block
`timescale 1ns/1ns
module tb_dlc_mode_clock_cfg;
  reg clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [7:0] addr_i = 8'h00;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg en = 1'b0;
  integer miscompares = 0;
  integer total_checks = 0;
  wire [7:0] rdata_o, in_a_clk_band_o;
  wire [23:0] in_a_data_i, in_b_data_i, out_a_data_o, out_b_data_o;
  wire cha_clk_i, ref_clk_i, in_a_valid_i, in_a_last_i, in_a_ready_o;
  wire in_b_valid_i, in_b_last_i, in_b_ready_o, out_a_valid_o, out_b_valid_o;
  wire out_b_enable_o, pix_tick_o, band_preset_o, pix_clk_o;
  wire [2:0] out_clk_band_o, mode_o;
  localparam [39:0] RA = {8'h0a, 8'h0b, 8'h10, 8'h12, 8'h18};
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  dlc_host_model host (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .a_ready_i(in_a_ready_o),
    .b_ready_i(in_b_ready_o), .cha_clk_o(cha_clk_i), .ref_clk_o(ref_clk_i),
    .a_data_o(in_a_data_i), .a_valid_o(in_a_valid_i), .a_last_o(in_a_last_i),
    .b_data_o(in_b_data_i), .b_valid_o(in_b_valid_i), .b_last_o(in_b_last_i));
  dlc_mode_clock_cfg dut (.*);
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task do_reset;
    begin
      @(posedge clk_i);
      en <= 1'b0;
      nrst_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
    end
  endtask
  // One idle cycle after each strobe keeps every request a single-cycle pulse
  task wr(input [7:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
      @(posedge clk_i);
    end
  endtask
  task wait_out(input sel);
    integer k;
    begin
      k = 0;
      @(negedge clk_i);
      while ((sel ? out_b_valid_o : out_a_valid_o) !== 1'b1 && k < 600) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (k == 600) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: no output pixel", $time);
        finish_test;
      end
    end
  endtask
  task count_ticks(input [31:0] lo, input [31:0] hi);
    integer n;
    reg p;
    begin
      n = 0;
      repeat (100) @(posedge clk_i);
      @(negedge clk_i);
      p = pix_clk_o;
      repeat (240) begin
        @(negedge clk_i);
        if (pix_tick_o === 1'b1) n = n + 1;
      end
      chk(n >= lo && n <= hi, 1);
      chk(pix_clk_o, p ^ n[0]);
    end
  endtask
  function [2:0] exp_mode(input lk, input lr, input [1:0] c);
    case (c)
      2'h1: exp_mode = lk ? 3'h0 : 3'h1;
      2'h0: exp_mode = 3'h2 + {lr, 1'b0} + {2'b00, ~lk};
      2'h2: exp_mode = lk ? 3'h7 : 3'h6;
      default: exp_mode = 3'h7;
    endcase
  endfunction
  task t_regs;
    integer i;
    reg [7:0] d;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        rd(RA[i*8 +: 8], d);
        chk(d, 8'h00);
        wr(RA[i*8 +: 8], 8'h5a ^ i[7:0]);
        rd(RA[i*8 +: 8], d);
        chk(d, 8'h5a ^ i[7:0]);
      end
      wr(8'h55, 8'hff);
      rd(8'h55, d);
      chk(d, 8'h00);
      wr(8'h0a, 8'h03);
      wr(8'h12, 8'h1e);
      @(negedge clk_i);
      chk({out_clk_band_o, in_a_clk_band_o, band_preset_o}, {3'h1, 8'h1e, 1'b1});
      @(posedge clk_i);
      wr(8'h12, 8'h1f);
      @(negedge clk_i);
      chk(band_preset_o, 0);
      @(posedge clk_i);
      $display("test regs done");
    end
  endtask
  task t_modes;
    integer i;
    reg [2:0] m;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        m = exp_mode(i[0], i[1], i[3:2]);
        wr(8'h18, {3'b000, i[0], 4'h0});
        wr(8'h10, {i[1], i[3:2], 5'h00});
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk(mode_o, m);
        chk(out_b_enable_o, m == 1 || m == 3 || m == 5 || m == 6);
        @(posedge clk_i);
      end
      $display("test modes done");
    end
  endtask
  task t_divide;
    integer k;
    begin
      do_reset;
      wr(8'h40, 8'h01);
      wr(8'h0a, 8'h03);
      wr(8'h0b, 8'h10);
      wr(8'h10, 8'h20);
      en <= 1'b1;
      for (k = 0; k < 2; k = k + 1) begin
        wait_out(0);
        chk(out_a_data_o, {16'h1327, k[6:0], 1'b0});
        chk({out_b_valid_o, out_b_data_o}, {1'b1, 16'h1327, k[6:0], 1'b1});
      end
      count_ticks(19, 21);
      $display("test divide done");
    end
  endtask
  task t_reference;
    begin
      do_reset;
      wr(8'h0b, 8'h01);
      count_ticks(23, 25);
      $display("test reference done");
    end
  endtask
  task t_streams;
    begin
      do_reset;
      wr(8'h0a, 8'h03);
      wr(8'h10, 8'h40);
      en <= 1'b1;
      wait_out(0);
      chk(out_a_data_o, 24'h102400);
      wait_out(1);
      chk({out_b_data_o[23:8], out_b_data_o[1:0]}, {16'h5468, 2'b00});
      $display("test streams done");
    end
  endtask
  task t_split;
    integer k;
    begin
      do_reset;
      wr(8'h40, 8'h01);
      wr(8'h0a, 8'h03);
      wr(8'h10, 8'h80);
      en <= 1'b1;
      for (k = 0; k < 3; k = k + 1) begin
        wait_out(0);
        chk(out_a_data_o, (k < 2) ? {16'h1327, k[6:0], 1'b0} : 24'h576b00);
        chk(out_b_data_o, (k < 2) ? {16'h1327, k[6:0], 1'b1} : 24'h576b01);
      end
      $display("test split done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_regs;
    t_modes;
    t_divide;
    t_reference;
    t_streams;
    t_split;
    finish_test;
  end
endmodule // tb_dlc_mode_clock_cfg
